// ===== pkg/msr_pkg.sv
// Constants, types and register map for the sleep and reset side-band controller
package msr_pkg;
  // Clock and timing
  localparam int unsigned MSR_CLK_HZ = 10000000;
  localparam int unsigned MSR_RST_HOLD_MS = 1000;
  localparam int unsigned MSR_RST_HOLD_CYC = MSR_RST_HOLD_MS * (MSR_CLK_HZ / 1000);
  localparam int unsigned MSR_RESLEEP_S = 120;
  localparam int unsigned MSR_RESLEEP_CYC = MSR_RESLEEP_S * MSR_CLK_HZ;
  localparam int unsigned MSR_UART_MAX_BPS = 4000000;
  localparam logic [15:0] MSR_BAUD_MIN_DIV =
    16'((MSR_CLK_HZ + MSR_UART_MAX_BPS - 1) / MSR_UART_MAX_BPS);
  localparam int MSR_HOLD_W = 24;
  localparam int MSR_TMR_W = 31;

  // Register byte offsets
  localparam logic [7:0] MSR_ADR_CTRL = 8'h00;
  localparam logic [7:0] MSR_ADR_STAT = 8'h04;
  localparam logic [7:0] MSR_ADR_IRQ_ST = 8'h08;
  localparam logic [7:0] MSR_ADR_IRQ_CLR = 8'h0c;
  localparam logic [7:0] MSR_ADR_IRQ_EN = 8'h10;
  localparam logic [7:0] MSR_ADR_BAUD = 8'h14;

  // Control register fields
  localparam int MSR_CTL_ARM = 0;
  localparam int MSR_CTL_RFSW = 1;
  localparam int MSR_CTL_PCM_M = 2;
  localparam int MSR_CTL_FLOW = 3;
  localparam int MSR_CTL_LAMP = 4;
  localparam int MSR_CTL_W = 5;

  // Status register fields
  localparam int MSR_STA_ASLEEP = 0;
  localparam int MSR_STA_CARD = 1;
  localparam int MSR_STA_RFOFF = 2;
  localparam int MSR_STA_STATE = 3;

  // Interrupt bits
  localparam int MSR_IRQ_CARD = 0;
  localparam int MSR_IRQ_WAKE = 1;
  localparam int MSR_IRQ_SLEEP = 2;
  localparam int MSR_IRQ_W = 3;

  // Power state machine
  typedef enum logic [1:0] {
    MSR_AWAKE = 2'b00,
    MSR_PEND = 2'b01,
    MSR_ASLEEP = 2'b10,
    MSR_EVT = 2'b11
  } msr_state_e;

  // Whole module state
  typedef struct packed {
    logic rst_a;
    logic rst_b;
    logic pin_a;
    logic pin_b;
    logic card_a;
    logic card_b;
    logic card_q;
    logic rfd_a;
    logic rfd_b;
    logic cts_a;
    logic cts_b;
    logic [MSR_CTL_W-1:0] ctrl;
    logic [15:0] baud;
    logic [MSR_IRQ_W-1:0] irq_st;
    logic [MSR_IRQ_W-1:0] irq_en;
    msr_state_e state;
    logic [MSR_HOLD_W-1:0] hold_cnt;
    logic hold_done;
    logic mod_rst;
    logic [MSR_TMR_W-1:0] tmr;
    logic svc_seen;
    logic urc;
    logic sleep_out;
    logic lamp_oe_n;
    logic rf_en;
    logic rts_n;
    logic tx_ok;
    logic irq;
    logic [31:0] rdata;
  } msr_st_s;

  // Reset image: reset, sleep and card pins and lamp enable idle high, CTS and RTS low
  localparam msr_st_s MSR_ST_RST = '{
    rst_a: 1'b1, rst_b: 1'b1, pin_a: 1'b1, pin_b: 1'b1,
    card_a: 1'b1, card_b: 1'b1, card_q: 1'b1,
    baud: MSR_BAUD_MIN_DIV, state: MSR_AWAKE,
    lamp_oe_n: 1'b1, rf_en: 1'b1, default: '0};
endpackage

// ===== core/msr_ctrl.sv
// Sleep, hard reset and side-band pin controller of the cellular module
//
// Contract
// R01 - Reset only after low over one second
// R02 - One UART, flow control, up to 4 Mbps
// R03 - Card input low means card present
// R04 - PCM port selectable as master or slave
// R05 - Lamp output driven low lights lamp
// R06 - Sleep pin ignored until power save armed
// R07 - Enter sleep only after work completes
// R08 - Pin high while asleep wakes device
// R09 - Network events wake, send unsolicited message
// R10 - Host raises pin, serves, lowers again
// R11 - Event wake re-sleeps two minutes later; here the two minutes count from i_service_done, and without it no re-sleep
// R12 - Indicator always reflects sleep state
// R13 - Radio disable with software enable kills RF
// R14 - Indicator high asleep; inputs synchronised
`timescale 1ns/100ps
`default_nettype none
module msr_ctrl
  import msr_pkg::*;
#(
  parameter int unsigned HOLD_CYC = MSR_RST_HOLD_CYC,
  parameter int unsigned RESLEEP_CYC = MSR_RESLEEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_hard_reset_n,
  input wire logic i_sleep_request_pin,
  input wire logic i_card_present_n,
  input wire logic i_radio_disable,
  input wire logic i_cts_n,
  input wire logic i_rx_full,
  input wire logic i_busy,
  input wire logic i_net_event,
  input wire logic i_service_done,
  output logic o_sleep_indicator_out,
  output logic o_network_lamp_n_out,
  output logic o_network_lamp_n_oe_n,
  output logic o_module_reset,
  output logic o_rf_enable,
  output logic o_urc_req,
  output logic o_rts_n,
  output logic o_tx_allow,
  output logic o_pcm_master,
  output logic [15:0] o_baud_div,
  output logic o_irq
);

  // Full state and its next value
  msr_st_s st_reg;
  msr_st_s st_next;

  // Hold and timer limits at counter width
  localparam logic [MSR_HOLD_W-1:0] HOLD_LIM = MSR_HOLD_W'(HOLD_CYC);
  localparam logic [MSR_TMR_W-1:0] TMR_LIM = MSR_TMR_W'(RESLEEP_CYC);

  // Next-state logic for the whole block
  always_comb begin
    logic armed;
    logic pin_hi;
    logic [MSR_IRQ_W-1:0] ev;
    logic [15:0] wb;
    armed = 1'b0;
    pin_hi = 1'b0;
    ev = '0;
    wb = '0;
    st_next = st_reg;

    // Two-stage synchronisers; first stage feeds only the second [R14]
    st_next.rst_a = i_hard_reset_n;
    st_next.rst_b = st_reg.rst_a;
    st_next.pin_a = i_sleep_request_pin;
    st_next.pin_b = st_reg.pin_a;
    st_next.card_a = i_card_present_n;
    st_next.card_b = st_reg.card_a;
    st_next.card_q = st_reg.card_b;
    st_next.rfd_a = i_radio_disable;
    st_next.rfd_b = st_reg.rfd_a;
    st_next.cts_a = i_cts_n;
    st_next.cts_b = st_reg.cts_a;

    // Hard reset: count a continuous low, fire once per low period
    st_next.mod_rst = 1'b0;
    if (st_reg.rst_b) begin
      // Any high level restarts the count, so short pulses do nothing
      st_next.hold_cnt = '0; // [R01]
      st_next.hold_done = 1'b0;
    end else if (!st_reg.hold_done) begin
      if (st_reg.hold_cnt >= HOLD_LIM) begin
        // Strictly longer than the hold time
        st_next.mod_rst = 1'b1; // [R01]
        st_next.hold_done = 1'b1;
      end else begin
        st_next.hold_cnt = st_reg.hold_cnt + 1'b1;
      end
    end

    // Sleep handshake
    armed = st_reg.ctrl[MSR_CTL_ARM];
    pin_hi = st_reg.pin_b;
    st_next.urc = 1'b0;
    case (st_reg.state)
      MSR_AWAKE: begin
        // Pin has no effect until armed [R06]
        if (armed && !pin_hi) begin
          st_next.state = MSR_PEND;
        end
      end
      MSR_PEND: begin
        if (!armed || pin_hi) begin
          st_next.state = MSR_AWAKE;
        end else if (!i_busy) begin
          // Work and pending transfers done [R07]
          st_next.state = MSR_ASLEEP;
          ev[MSR_IRQ_SLEEP] = 1'b1;
        end
      end
      MSR_ASLEEP: begin
        if (!armed || pin_hi) begin
          // Host raised the pin [R08]
          st_next.state = MSR_AWAKE;
        end else if (i_net_event) begin
          // Call, data or message: wake and report [R09]
          st_next.state = MSR_EVT;
          st_next.urc = 1'b1; // [R09]
          st_next.svc_seen = 1'b0;
          st_next.tmr = '0;
          ev[MSR_IRQ_WAKE] = 1'b1;
        end
      end
      MSR_EVT: begin
        if (!armed || pin_hi) begin
          // Host took over as expected [R10]
          st_next.state = MSR_AWAKE;
        end else if (!st_reg.svc_seen) begin
          st_next.svc_seen = i_service_done;
        end else if (st_reg.tmr >= TMR_LIM - 1'b1) begin
          // Back through the idle check [R11]
          st_next.state = MSR_PEND;
        end else begin
          st_next.tmr = st_reg.tmr + 1'b1; // [R11]
        end
      end
      default: begin
        st_next.state = MSR_AWAKE;
      end
    endcase

    // Indicator high exactly while asleep [R12] [R14]
    st_next.sleep_out = (st_next.state == MSR_ASLEEP);

    // Card insert or removal raises an event [R03]
    ev[MSR_IRQ_CARD] = st_reg.card_b ^ st_reg.card_q;

    // Radio off needs both pin and software enable [R13]
    st_next.rf_en = !(st_reg.rfd_b && st_reg.ctrl[MSR_CTL_RFSW]);

    // Lamp pulled low to light, released otherwise [R05]
    st_next.lamp_oe_n = !st_reg.ctrl[MSR_CTL_LAMP];

    // Flow control: stop peer when receive side is full [R02]
    st_next.rts_n = st_reg.ctrl[MSR_CTL_FLOW] && i_rx_full;
    st_next.tx_ok = !st_reg.ctrl[MSR_CTL_FLOW] || !st_reg.cts_b;

    // Register writes
    if (i_wr) begin
      case (i_addr)
        MSR_ADR_CTRL: begin
          st_next.ctrl = i_wdata[MSR_CTL_W-1:0];
        end
        MSR_ADR_IRQ_EN: begin
          st_next.irq_en = i_wdata[MSR_IRQ_W-1:0];
        end
        MSR_ADR_BAUD: begin
          // Clamp so the bit rate never passes the ceiling [R02]
          wb = i_wdata[15:0];
          st_next.baud = (wb < MSR_BAUD_MIN_DIV) ? MSR_BAUD_MIN_DIV : wb;
        end
        default: begin
        end
      endcase
    end

    // Sticky status: a same-cycle event beats the clear
    if (i_wr && i_addr == MSR_ADR_IRQ_CLR) begin
      st_next.irq_st = (st_reg.irq_st & ~i_wdata[MSR_IRQ_W-1:0]) | ev;
    end else begin
      st_next.irq_st = st_reg.irq_st | ev;
    end
    st_next.irq = |(st_next.irq_st & st_reg.irq_en);

    // Read data valid only in the cycle after the strobe
    st_next.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        MSR_ADR_CTRL: begin
          st_next.rdata[MSR_CTL_W-1:0] = st_reg.ctrl;
        end
        MSR_ADR_STAT: begin
          st_next.rdata[MSR_STA_ASLEEP] = st_reg.sleep_out;
          st_next.rdata[MSR_STA_CARD] = !st_reg.card_b; // [R03]
          st_next.rdata[MSR_STA_RFOFF] = !st_reg.rf_en;
          st_next.rdata[MSR_STA_STATE+1:MSR_STA_STATE] = st_reg.state;
        end
        MSR_ADR_IRQ_ST: begin
          st_next.rdata[MSR_IRQ_W-1:0] = st_reg.irq_st;
        end
        MSR_ADR_IRQ_EN: begin
          st_next.rdata[MSR_IRQ_W-1:0] = st_reg.irq_en;
        end
        MSR_ADR_BAUD: begin
          st_next.rdata[15:0] = st_reg.baud;
        end
        default: begin
          // Unmapped and write-only offsets read zero
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= MSR_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops, except the lamp pin level tied low
  assign o_rdata = st_reg.rdata;
  assign o_sleep_indicator_out = st_reg.sleep_out;
  assign o_network_lamp_n_out = 1'b0;
  assign o_network_lamp_n_oe_n = st_reg.lamp_oe_n;
  assign o_module_reset = st_reg.mod_rst;
  assign o_rf_enable = st_reg.rf_en;
  assign o_urc_req = st_reg.urc;
  assign o_rts_n = st_reg.rts_n;
  assign o_tx_allow = st_reg.tx_ok;
  // Master drives clock and sync, slave accepts them [R04]
  assign o_pcm_master = st_reg.ctrl[MSR_CTL_PCM_M];
  assign o_baud_div = st_reg.baud;
  assign o_irq = st_reg.irq;

endmodule
`default_nettype wire

// ===== verification/msr_ctrl_asserts.sv
// Port checker for the sleep and reset controller
`timescale 1ns/100ps
`default_nettype none
module msr_ctrl_asserts
  import msr_pkg::*;
#(parameter int unsigned HOLD_CYC = MSR_RST_HOLD_CYC) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hard_reset_n,
  input wire logic i_sleep_request_pin,
  input wire logic i_busy,
  input wire logic i_net_event,
  input wire logic o_sleep_indicator_out,
  input wire logic o_network_lamp_n_out,
  input wire logic o_module_reset,
  input wire logic o_urc_req,
  input wire logic [15:0] o_baud_div
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Raw low run of the reset pin; saturates so it never wraps
  logic [31:0] low_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) low_reg <= '0;
    else if (i_hard_reset_n) low_reg <= '0;
    else if (low_reg != 32'hffffffff) low_reg <= low_reg + 32'h1;
  end
  // Event while asleep, then the wake answer
  sequence s_evt; o_sleep_indicator_out && i_net_event; endsequence
  sequence s_ans; o_urc_req && !o_sleep_indicator_out; endsequence
  property p_evt; s_evt |=> s_ans; endproperty
  a_evt: assert property (p_evt) else $error("event wake missed");
  property p_urc_src; o_urc_req |-> $past(i_net_event); endproperty
  a_urc_src: assert property (p_urc_src) else $error("message without event");
  property p_urc_one; o_urc_req |=> !o_urc_req; endproperty
  a_urc_one: assert property (p_urc_one) else $error("message pulse too long");
  property p_rst_one; o_module_reset |=> !o_module_reset; endproperty
  a_rst_one: assert property (p_rst_one) else $error("reset pulse too long");
  property p_rst_long; o_module_reset |-> low_reg >= HOLD_CYC; endproperty
  a_rst_long: assert property (p_rst_long) else $error("reset on short low");
  property p_pin; o_sleep_indicator_out ##0 i_sleep_request_pin [*3] |=> !o_sleep_indicator_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin high did not wake");
  property p_idle; $rose(o_sleep_indicator_out) |-> !$past(i_busy); endproperty
  a_idle: assert property (p_idle) else $error("slept while busy");
  property p_lamp; o_network_lamp_n_out == 1'b0; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp pin level not low");
  property p_baud; o_baud_div >= MSR_BAUD_MIN_DIV; endproperty
  a_baud: assert property (p_baud) else $error("divisor too small");
endmodule
bind msr_ctrl msr_ctrl_asserts #(.HOLD_CYC(HOLD_CYC)) chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_hard_reset_n(i_hard_reset_n), .i_sleep_request_pin(i_sleep_request_pin), .i_busy(i_busy),
  .i_net_event(i_net_event), .o_sleep_indicator_out(o_sleep_indicator_out),
  .o_network_lamp_n_out(o_network_lamp_n_out), .o_module_reset(o_module_reset),
  .o_urc_req(o_urc_req), .o_baud_div(o_baud_div));
`default_nettype wire

// ===== verification/msr_host.sv
// Host controller model on the module's side-band pins
`timescale 1ns/100ps
`default_nettype none
module msr_host (
  input wire logic i_clk,
  input wire logic i_urc_req,
  output logic o_sleep_request_pin,
  output logic o_hard_reset_n,
  output logic o_radio_disable,
  output logic o_card_present_n
);
  logic answer = 1'b0; // Obeys wake messages only when set
  // Idle levels: pin high before arming, no card
  initial begin
    o_sleep_request_pin = 1'b1;
    o_hard_reset_n = 1'b1;
    o_radio_disable = 1'b0;
    o_card_present_n = 1'b1;
  end
  // Raise the pin first on a wake message; serving comes later
  always @(posedge i_clk) begin
    if (answer && i_urc_req) o_sleep_request_pin <= 1'b1;
  end
  // New pin levels just after an edge
  task automatic pins(input logic s, input logic r, input logic d, input logic c);
    @(posedge i_clk);
    o_sleep_request_pin <= s;
    o_hard_reset_n <= r;
    o_radio_disable <= d;
    o_card_present_n <= c;
  endtask
endmodule
`default_nettype wire

// ===== verification/msr_ctrl_bench.sv
// Self-checking bench for the sleep and reset controller
`timescale 1ns/100ps
`default_nettype none
module msr_ctrl_bench
  import msr_pkg::*;
();
  localparam int unsigned HOLD = 20; // Short hold count keeps the run brief
  localparam int unsigned SLP = 50; // Short re-sleep delay
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rx_full = 1'b0;
  logic busy = 1'b0;
  logic ev = 1'b0;
  logic done = 1'b0;
  logic cts_n = 1'b0; // Peer clear-to-send, low lets us send
  logic tx_ok;
  logic hrst_n, pin, card_n, rfd, slp, lamp_oe_n, mrst, rf_en, urc, rts_n, pcm_m, irq;
  logic [31:0] rdata;
  logic [15:0] baud;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int pulses = 0;
  always #50 clk = ~clk;
  msr_host host (.i_clk(clk), .i_urc_req(urc), .o_sleep_request_pin(pin),
    .o_hard_reset_n(hrst_n), .o_radio_disable(rfd), .o_card_present_n(card_n));
  msr_ctrl #(.HOLD_CYC(HOLD), .RESLEEP_CYC(SLP)) dut (.i_clk(clk), .i_resetn(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_hard_reset_n(hrst_n), .i_sleep_request_pin(pin), .i_card_present_n(card_n),
    .i_radio_disable(rfd), .i_cts_n(cts_n), .i_rx_full(rx_full), .i_busy(busy),
    .i_net_event(ev), .i_service_done(done), .o_sleep_indicator_out(slp),
    .o_network_lamp_n_out(), .o_network_lamp_n_oe_n(lamp_oe_n), .o_module_reset(mrst),
    .o_rf_enable(rf_en), .o_urc_req(urc), .o_rts_n(rts_n), .o_tx_allow(tx_ok),
    .o_pcm_master(pcm_m), .o_baud_div(baud), .o_irq(irq));
  // Cycle ceiling against hangs; also counts reset pulses
  always @(posedge clk) begin
    cyc++;
    if (mrst === 1'b1) pulses++;
    if (cyc == 3000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Bus cycles; read data is taken in the one cycle it stands
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
  endtask
  // Wait edges, then look where outputs have settled
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input bit e);
    @(posedge clk);
    if (e) ev <= 1'b1;
    else done <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    done <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, divisor floor
    rdc(MSR_ADR_CTRL, 32'h0, "ctrl");
    rdc(MSR_ADR_STAT, 32'h0, "stat");
    rdc(MSR_ADR_BAUD, {16'h0, MSR_BAUD_MIN_DIV}, "baud");
    rdc(8'h1c, 32'h0, "unmapped");
    wrr(MSR_ADR_BAUD, 32'h1);
    rdc(MSR_ADR_BAUD, {16'h0, MSR_BAUD_MIN_DIV}, "baud floor");
    wrr(MSR_ADR_BAUD, 32'h28);
    st(1);
    chk("baud out", 32'h28, {16'h0, baud});
    chk("tx free", 32'h1, {31'h0, tx_ok});
    $display("registers done");
    // Port modes, lamp, flow stop, radio gate
    wrr(MSR_ADR_CTRL, 32'h1c);
    rx_full <= 1'b1;
    cts_n <= 1'b1;
    host.pins(1'b1, 1'b1, 1'b1, 1'b1);
    st(4);
    chk("pcm", 32'h1, {31'h0, pcm_m});
    chk("lamp on", 32'h0, {31'h0, lamp_oe_n});
    chk("rts_n", 32'h1, {31'h0, rts_n});
    chk("tx stop", 32'h0, {31'h0, tx_ok});
    chk("rf no sw", 32'h1, {31'h0, rf_en});
    wrr(MSR_ADR_CTRL, 32'h02);
    st(3);
    chk("rf off", 32'h0, {31'h0, rf_en});
    chk("lamp off", 32'h1, {31'h0, lamp_oe_n});
    rdc(MSR_ADR_STAT, 32'h4, "stat rf");
    rx_full <= 1'b0;
    cts_n <= 1'b0;
    host.pins(1'b1, 1'b1, 1'b0, 1'b1);
    wrr(MSR_ADR_CTRL, 32'h0);
    $display("control done");
    // Card insert: masked, raised, cleared
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    st(6);
    chk("irq masked", 32'h0, {31'h0, irq});
    wrr(MSR_ADR_IRQ_EN, 32'h1);
    st(2);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(MSR_ADR_STAT, 32'h2, "card");
    rdc(MSR_ADR_IRQ_ST, 32'h1, "irq st");
    wrr(MSR_ADR_IRQ_CLR, 32'h1);
    st(2);
    chk("irq clr", 32'h0, {31'h0, irq});
    $display("card done");
    // Sleep entry needs arming and idle; pin high wakes
    host.pins(1'b0, 1'b1, 1'b0, 1'b0);
    st(6);
    chk("unarmed", 32'h0, {31'h0, slp});
    busy <= 1'b1;
    wrr(MSR_ADR_CTRL, 32'h1);
    st(8);
    chk("busy", 32'h0, {31'h0, slp});
    rdc(MSR_ADR_STAT, 32'h0a, "pending");
    busy <= 1'b0;
    st(3);
    chk("asleep", 32'h1, {31'h0, slp});
    rdc(MSR_ADR_STAT, 32'h13, "stat asleep");
    rdc(MSR_ADR_IRQ_ST, 32'h4, "sleep st");
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    st(4);
    chk("woken", 32'h0, {31'h0, slp});
    $display("sleep done");
    // Event wake: silent host back to sleep after the delay, answering host held awake
    host.pins(1'b0, 1'b1, 1'b0, 1'b0);
    st(5);
    pulse(1'b1);
    st(0);
    chk("urc", 32'h1, {31'h0, urc});
    chk("ev awake", 32'h0, {31'h0, slp});
    pulse(1'b0);
    st(SLP - 8);
    chk("not yet", 32'h0, {31'h0, slp});
    st(12);
    chk("resleep", 32'h1, {31'h0, slp});
    host.answer = 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    st(SLP + 10);
    chk("held awake", 32'h0, {31'h0, slp});
    host.answer = 1'b0;
    $display("event done");
    // Short low ignored, long low gives one pulse
    host.pins(1'b1, 1'b0, 1'b0, 1'b0);
    st(10);
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    st(4);
    chk("short low", 32'h0, 32'(pulses));
    host.pins(1'b1, 1'b0, 1'b0, 1'b0);
    st(HOLD + 10);
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    st(4);
    chk("long low", 32'h1, 32'(pulses));
    $display("reset done");
    conclude();
  end
endmodule
`default_nettype wire
